// ### logic/spb_defines.svh
`ifndef SPB_DEFINES_SVH
`define SPB_DEFINES_SVH

// Pipe timing
`define SPB_CLK_PERIOD_NS  20
`define SPB_PIPE_PERIOD_NS 134
`define SPB_PIPE_CYCLES    ((`SPB_PIPE_PERIOD_NS + `SPB_CLK_PERIOD_NS - 1) / `SPB_CLK_PERIOD_NS)
`define SPB_LOAD_DELAY     3'h6

// Segment fields
`define SPB_WIDTH_MAX      11'h7ff
`define SPB_LZC_SAT        4'h9
`define SPB_RECIP_FLAT     10'h200
`define SPB_ROUND_HALF     17'h00040
`define SPB_MANT_IMPLIED   2'h1

// Write counter, -1 and -2 in two's complement form
`define SPB_CNT_FULL       8'hff
`define SPB_CNT_FIRST      8'hfe
`define SPB_CNT_STEP       8'h01

// Buffer shape
`define SPB_BUF_DEPTH      256
`define SPB_WORD_W         60
`define SPB_MARK_POS       0

// Table load word on the memory input bus
`define SPB_TBL_ADDR_LSB   0
`define SPB_TBL_ADDR_MSB   7
`define SPB_TBL_DATA_LSB   8
`define SPB_TBL_DATA_MSB   18

`endif

// ### logic/spb_pkg.sv
`include "spb_defines.svh"
`default_nettype none
package spb_pkg;
   typedef logic [`SPB_WORD_W-1:0] spb_word_t;

   typedef struct packed {
      logic [2:0]  divCnt;
      logic        pipe_clock_enable;
      logic        armed;
      logic [2:0]  delay;
      logic        clearPulse;
      logic        sel;
      logic        sawValid;
      logic        v6;
      logic [10:0] w6;
      logic [9:0]  r6;
      logic [7:0]  db6;
      logic [11:0] c6;
      logic        f6;
      logic        ltf6;
      logic        m6;
      logic        v7;
      logic [10:0] w7;
      logic [3:0]  n7;
      logic [9:0]  g7;
      logic [11:0] c7;
      logic        f7;
      logic        ltf7;
      logic        m7;
      logic        v8;
      logic        dx8;
      logic [7:0]  db8;
      logic [11:0] c8;
      logic        e8;
      logic [7:0]  cnt;
   } spb_state_t;

   typedef struct packed {
      spb_word_t outWord;
   } spb_buf_state_t;
endpackage
`default_nettype wire

// ### logic/spb_recip_lut.sv
`default_nettype none
module spb_recip_lut (
   // Clock
   input  wire logic        core_clk,
   // Table load from the memory input bus
   input  wire logic        tableWrite,
   input  wire logic        tableAddressSelect,
   input  wire logic [18:0] memDataIn,
   // Look-up
   input  wire logic [10:0] width,
   input  wire logic        flat,
   output logic      [9:0]  recip
);
   import spb_pkg::*;

   // Mantissa in [7:0], correction bits in [10:8]
   logic [10:0] table_q [0:255];
   logic [7:0]  tableAddress;
   logic [9:0]  halfWidth;
   logic [9:0]  shifted;
   logic [10:0] entry;
   logic [9:0]  base;
   logic [9:0]  corr;

   assign tableAddress = memDataIn[`SPB_TBL_ADDR_MSB:`SPB_TBL_ADDR_LSB];

   // Loader keeps address and data steady around the strobe
   always_ff @(posedge core_clk) begin
      if (tableAddressSelect && tableWrite) begin // RULE4
         table_q[tableAddress] <= memDataIn[`SPB_TBL_DATA_MSB:`SPB_TBL_DATA_LSB];
      end
   end

   always_comb begin
      halfWidth = width[10:1];
      if (halfWidth[9:8] == 2'h0) begin // RULE1
         shifted = {halfWidth[7:0], 2'h0};
      end else if (!halfWidth[9]) begin
         shifted = {halfWidth[8:0], 1'h0};
      end else begin
         shifted = halfWidth;
      end
      entry = table_q[shifted[9:2]]; // RULE1
      // Top two bits implied, never stored
      base = {`SPB_MANT_IMPLIED, entry[7:0]}; // RULE3
      case (shifted[1:0]) // RULE2
         2'h3: corr = 10'h001;
         2'h2: corr = 10'h001 + 10'(entry[8]);
         2'h1: corr = 10'h001 + 10'(entry[8]) + 10'(entry[9]);
         default: corr = 10'h001 + 10'(entry[8]) + 10'(entry[9]) + 10'(entry[10]);
      endcase
      recip = flat ? `SPB_RECIP_FLAT : base + corr; // RULE3
   end
endmodule
`default_nettype wire

// ### logic/spb_seg_buffer.sv
`default_nettype none
module spb_seg_buffer (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst,
   // Load side
   input  wire spb_pkg::spb_word_t loadWord,
   input  wire logic             loadShift,
   input  wire logic             loadSelect,
   // Unload side
   input  wire logic             unloadShift,
   output spb_pkg::spb_word_t    unloadWord
);
   import spb_pkg::*;

   // Shifting all words costs area but needs no address logic
   spb_word_t      bufs [0:1][0:`SPB_BUF_DEPTH-1];
   spb_buf_state_t s_q;
   spb_buf_state_t s_d;
   spb_word_t      noMark;

   always_comb begin
      noMark = loadWord;
      noMark[`SPB_MARK_POS] = 1'b0; // RULE18
   end

   always_ff @(posedge core_clk) begin
      for (int b = 0; b < 2; b++) begin
         // Loading half shifts on the write enable, other half on the reader
         if ((loadSelect == b[0]) ? loadShift : unloadShift) begin // RULE19 RULE24
            for (int k = `SPB_BUF_DEPTH - 1; k > 0; k--) begin
               bufs[b][k] <= bufs[b][k-1];
            end
            bufs[b][0] <= (loadSelect == b[0]) ? loadWord : noMark; // RULE18 RULE20
         end
      end
   end

   always_comb begin
      s_d = s_q;
      if (unloadShift) begin // RULE24
         s_d.outWord = bufs[~loadSelect][`SPB_BUF_DEPTH-1]; // RULE19
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign unloadWord = s_q.outWord;

   a_unload_hold: assert property (@(posedge core_clk) disable iff (rst)
      !unloadShift |=> unloadWord == $past(unloadWord)) // RULE24
      else $error("unload word changed without shift");
endmodule
`default_nettype wire

// ### logic/spb_segment_pack.sv
// Function
// [RULE1] Shift out two zeros, index upper eight
// [RULE2] Low two bits pick correction bits added
// [RULE3] Reciprocal ten bits, top bits implied, max 512
// [RULE4] Loader writes table word under select strobe
// [RULE5] Level 6 registers; final segment gets max width
// [RULE6] Gradient is difference times reciprocal, rounded
// [RULE7] Leading zero count saturating at nine, level 7
// [RULE8] Wide segments store from level 7
// [RULE9] Narrow after stored segment waits for pairing
// [RULE10] Level 8 holds narrow segment fields, enable
// [RULE11] Write enable gated by pipe and not-full
// [RULE12] Counter counts stored words, clear forces -1
// [RULE13] Full at -1 except first segment, sets -2
// [RULE14] Narrow first segment passes marker to next
// [RULE15] First means valid after invalid segment
// [RULE16] Empty decode period flags last segment valid
// [RULE17] Nulls shift in after valid block until full
// [RULE18] Marker forced low into unloaded half
// [RULE19] Two shift buffers, one loads, one unloads
// [RULE20] Loading buffer shifts on each enabled period
// [RULE21] Load cycle starts six pipe clocks after scan
// [RULE22] Set marker flags first word of scanline
// [RULE23] Pipe stalls on invalid edge inside block
// [RULE24] Reader shifts unloaded half with own enable
//
// The plain strobed port and the register offsets were chosen for this implementation.
`default_nettype none
module spb_segment_pack (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // Segment from level 5
   input  wire logic        segValid,
   input  wire logic [10:0] segWidth,
   input  wire logic [7:0]  segBrightDiff,
   input  wire logic [11:0] segColor,
   input  wire logic        segFlat,
   input  wire logic        validNotFinal,
   input  wire logic        widthBelowFour,
   // Edge bus status
   input  wire logic        busEdgeValid,
   input  wire logic        busEdgeInBlock,
   // Scan timing
   input  wire logic        scanStart,
   input  wire logic        decodeLast,
   // Table load
   input  wire logic        tableWrite,
   input  wire logic        tableAddressSelect,
   input  wire logic [18:0] memDataIn,
   // Unload side
   input  wire logic        unloadShift,
   // Status and data out
   output logic             pipeClockEnable,
   output logic             loadCycleClear,
   output logic             loadSelect,
   output logic      [7:0]  writeCount,
   output spb_pkg::spb_word_t unloadWord
);
   import spb_pkg::*;

   spb_state_t s_q;
   spb_state_t s_d;
   logic [9:0] recip;
   logic       effValid;
   logic       pending8;
   logic       writeEnable;
   logic       segmentBufferNotFull;
   logic       bufferWriteClockEnable;
   logic       tick;
   logic       loadStart;
   spb_word_t  packed_w;

   function automatic logic [3:0] lead_zeros(input logic [10:0] w);
      logic [3:0] n;
      n = `SPB_LZC_SAT;
      for (int i = 0; i < 9; i++) begin
         if (w[10-i] && n == `SPB_LZC_SAT) begin
            n = 4'(i);
         end
      end
      return n;
   endfunction

   // Magnitude plus sign in, magnitude plus sign out
   function automatic logic [9:0] gradient(input logic [7:0] db, input logic [9:0] r);
      logic [16:0] p;
      p = 17'(db[6:0]) * 17'(r) + `SPB_ROUND_HALF;
      return {db[7], p[15:7]};
   endfunction

   spb_recip_lut u_lut (
      .core_clk           (core_clk),
      .tableWrite         (tableWrite),
      .tableAddressSelect (tableAddressSelect),
      .memDataIn          (memDataIn),
      .width              (segWidth),
      .flat               (segFlat),
      .recip              (recip)
   );

   always_comb begin
      tick = s_q.divCnt == 3'(`SPB_PIPE_CYCLES - 1);
      loadStart = s_q.armed && s_q.pipe_clock_enable && s_q.delay == `SPB_LOAD_DELAY - 3'h1; // RULE21
      // Nothing valid seen this period: last segment stands in
      effValid = segValid || (decodeLast && !s_q.sawValid); // RULE16
      pending8 = s_q.v8 && !s_q.e8;
      // Null words keep shifting once the valid block has passed
      writeEnable = !s_q.v7 || !s_q.ltf7 || pending8; // RULE8 RULE9 RULE17
      segmentBufferNotFull = (s_q.cnt != `SPB_CNT_FULL) || s_q.m7; // RULE13
      bufferWriteClockEnable = writeEnable && s_q.pipe_clock_enable && segmentBufferNotFull; // RULE11
   end

   // Level 8 part high, level 7 part low, marker at bit 0
   assign packed_w = {s_q.dx8, s_q.db8, s_q.c8, s_q.e8,
                      s_q.w7, s_q.n7[2:0], s_q.g7, s_q.f7, s_q.c7, s_q.m7}; // RULE22

   always_comb begin
      s_d = s_q;
      s_d.divCnt = tick ? 3'h0 : s_q.divCnt + 3'h1;
      // Stall keeps valid edges adjacent in the pipe
      s_d.pipe_clock_enable = tick && !(!busEdgeValid && busEdgeInBlock); // RULE23
      s_d.clearPulse = 1'b0;

      if (scanStart) begin
         s_d.armed = 1'b1;
         s_d.delay = 3'h0;
      end else if (s_q.armed && s_q.pipe_clock_enable) begin
         s_d.delay = s_q.delay + 3'h1;
         if (loadStart) begin // RULE21
            s_d.armed = 1'b0;
            s_d.clearPulse = 1'b1;
            s_d.sel = !s_q.sel;
         end
      end

      if (s_q.pipe_clock_enable) begin
         // Level 6
         s_d.v6 = effValid; // RULE5
         s_d.w6 = validNotFinal ? segWidth : `SPB_WIDTH_MAX; // RULE5
         s_d.r6 = recip;
         s_d.db6 = segBrightDiff;
         s_d.c6 = segColor;
         s_d.f6 = segFlat;
         s_d.ltf6 = widthBelowFour;
         s_d.m6 = effValid && !s_q.v6; // RULE15
         // Level 7
         s_d.v7 = s_q.v6; // RULE7
         s_d.w7 = s_q.w6;
         s_d.n7 = lead_zeros(s_q.w6); // RULE7
         s_d.g7 = gradient(s_q.db6, s_q.r6); // RULE6
         s_d.c7 = s_q.c6;
         s_d.f7 = s_q.f6;
         s_d.ltf7 = s_q.ltf6;
         // Unstored first segment hands its marker on
         s_d.m7 = s_q.m6 || (s_q.m7 && !writeEnable); // RULE14
         // Level 8
         s_d.v8 = s_q.v7; // RULE10
         s_d.dx8 = s_q.w7[0];
         s_d.db8 = {s_q.g7[9], s_q.g7[8:2]}; // RULE10
         s_d.c8 = s_q.c7;
         s_d.e8 = writeEnable; // RULE10
      end

      // Set wins over the clear of the same cycle
      if (s_q.pipe_clock_enable && effValid) begin
         s_d.sawValid = 1'b1;
      end else if (loadStart) begin
         s_d.sawValid = 1'b0;
      end

      if (loadStart) begin
         s_d.cnt = `SPB_CNT_FULL; // RULE12
      end else if (bufferWriteClockEnable) begin
         s_d.cnt = s_q.m7 ? `SPB_CNT_FIRST : s_q.cnt + `SPB_CNT_STEP; // RULE12 RULE13
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_q <= '0;
         s_q.cnt <= `SPB_CNT_FULL;
      end else begin
         s_q <= s_d;
      end
   end

   spb_seg_buffer u_buf (
      .core_clk    (core_clk),
      .rst         (rst),
      .loadWord    (packed_w),
      .loadShift   (bufferWriteClockEnable), // RULE20
      .loadSelect  (s_q.sel),
      .unloadShift (unloadShift),
      .unloadWord  (unloadWord)
   );

   assign pipeClockEnable = s_q.pipe_clock_enable;
   assign loadCycleClear = s_q.clearPulse;
   assign loadSelect = s_q.sel;
   assign writeCount = s_q.cnt;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   a_pipe_stall: assert property (
      pipeClockEnable |-> $past(busEdgeValid || !busEdgeInBlock)) // RULE23
      else $error("pipe advanced on an invalid in-block edge");

   a_pipe_spacing: assert property (
      pipeClockEnable |=> !pipeClockEnable [*6]) // RULE23
      else $error("pipe enable came faster than one pipe period");

   a_full_block: assert property (
      (writeCount == `SPB_CNT_FULL && !s_q.m7) |-> !bufferWriteClockEnable) // RULE11
      else $error("write at full counter without first marker");

   a_clear_count: assert property (
      loadCycleClear |-> writeCount == `SPB_CNT_FULL) // RULE12
      else $error("load cycle clear did not force counter to -1");

   a_count_step: assert property (
      (bufferWriteClockEnable && !s_q.m7) |=>
      loadCycleClear || writeCount == $past(writeCount) + `SPB_CNT_STEP) // RULE12
      else $error("counter did not step on a stored word");

   a_first_reload: assert property (
      (bufferWriteClockEnable && s_q.m7) |=>
      loadCycleClear || writeCount == `SPB_CNT_FIRST) // RULE13
      else $error("first word did not set counter to -2");

   a_wide_store: assert property (
      (s_q.pipe_clock_enable && s_q.v7 && !s_q.ltf7 && segmentBufferNotFull)
      |-> bufferWriteClockEnable) // RULE8
      else $error("wide segment not stored from level 7");

   a_narrow_hold: assert property (
      (s_q.pipe_clock_enable && s_q.v7 && s_q.ltf7 && !pending8) |-> !bufferWriteClockEnable) // RULE9
      else $error("narrow segment stored without its pair");

   a_null_fill: assert property (
      (s_q.pipe_clock_enable && !s_q.v7 && segmentBufferNotFull) |-> bufferWriteClockEnable) // RULE17
      else $error("null word not shifted after valid block");

   a_final_width: assert property (
      (s_q.pipe_clock_enable && !validNotFinal) |=> s_q.w6 == `SPB_WIDTH_MAX) // RULE5
      else $error("final segment width not forced to maximum");

   a_first_mark: assert property (
      (s_q.pipe_clock_enable && effValid && !s_q.v6) |=> s_q.m6) // RULE15
      else $error("first segment not marked");

   a_mark_carry: assert property (
      (s_q.pipe_clock_enable && s_q.m7 && !writeEnable) |=> s_q.m7) // RULE14
      else $error("marker lost for unstored first segment");

   a_level8_enable: assert property (
      s_q.pipe_clock_enable |=> s_q.e8 == $past(writeEnable) && s_q.dx8 == $past(s_q.w7[0])) // RULE10
      else $error("level 8 did not capture enable and width bit");

   a_select_swap: assert property (
      loadCycleClear |-> loadSelect != $past(loadSelect)) // RULE21
      else $error("buffer roles not swapped at load cycle start");

   a_lzc_sat: assert property (
      (s_q.pipe_clock_enable && s_q.w6 == 11'h000) |=> s_q.n7 == `SPB_LZC_SAT) // RULE7
      else $error("zero width leading count not nine");

   c_pair_store: cover property (bufferWriteClockEnable && pending8 && s_q.v7);
   c_first_narrow: cover property (s_q.pipe_clock_enable && s_q.m7 && !writeEnable);
   c_buffer_full: cover property (s_q.pipe_clock_enable && !segmentBufferNotFull);
   c_load_start: cover property (loadCycleClear ##1 bufferWriteClockEnable [*1]);
endmodule
`default_nettype wire

// ### sim/spb_video_reader.sv
`default_nettype none
module spb_video_reader (
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               rst,
   // Control from the bench
   input  wire logic               readStart,
   // Buffer side
   input  wire spb_pkg::spb_word_t unloadWord,
   output logic                    unloadShift,
   // Result
   output logic                    found,
   output spb_pkg::spb_word_t      foundWord
);
   timeunit 1ns;
   timeprecision 1ns;
   import spb_pkg::*;

   logic       busy;
   logic [8:0] left;

   // Search shifts every other cycle, so each new output word is seen settled
   always_ff @(posedge core_clk) begin
      if (rst) begin
         busy        <= 1'b0;
         unloadShift <= 1'b0;
         found       <= 1'b0;
         left        <= 9'h000;
         foundWord   <= '0;
      end else if (readStart) begin
         busy        <= 1'b1;
         found       <= 1'b0;
         left        <= 9'h12c;
         unloadShift <= 1'b1;
      end else if (busy && !unloadShift) begin
         if (unloadWord[0] === 1'b1) begin
            busy      <= 1'b0;
            found     <= 1'b1;
            foundWord <= unloadWord;
         end else if (left != 9'h000) begin
            unloadShift <= 1'b1;
            left        <= left - 9'h001;
         end else begin
            busy <= 1'b0;
         end
      end else begin
         unloadShift <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### sim/test_segment_pack_and_buffer_write.sv
`default_nettype none
module test_segment_pack_and_buffer_write;
   timeunit 1ns;
   timeprecision 1ns;
   import spb_pkg::*;

   logic core_clk = 1'b0, rst = 1'b1, segValid = 1'b0, segFlat = 1'b0;
   logic [10:0] segWidth = 11'h000;
   logic [7:0]  segBrightDiff = 8'h00;
   logic [11:0] segColor = 12'h000;
   logic validNotFinal = 1'b0, widthBelowFour = 1'b0, busEdgeValid = 1'b1;
   logic busEdgeInBlock = 1'b0, scanStart = 1'b0, tableWrite = 1'b0;
   logic tableAddressSelect = 1'b0, readStart = 1'b0, decodeLast = 1'b0;
   logic [18:0] memDataIn = 19'h00000;
   logic unloadShift, pipeClockEnable, loadCycleClear, loadSelect, found;
   logic [7:0] writeCount, prevCnt;
   spb_word_t unloadWord, foundWord;
   logic [7:0] seen[$];
   int errors = 0, checks = 0, cycles = 0, n, k;

   always #10 core_clk = ~core_clk;

   spb_segment_pack u_spb_segment_pack (.core_clk(core_clk), .rst(rst), .segValid(segValid),
      .segWidth(segWidth), .segBrightDiff(segBrightDiff), .segColor(segColor),
      .segFlat(segFlat), .validNotFinal(validNotFinal), .widthBelowFour(widthBelowFour),
      .busEdgeValid(busEdgeValid), .busEdgeInBlock(busEdgeInBlock), .scanStart(scanStart),
      .decodeLast(decodeLast), .tableWrite(tableWrite), .tableAddressSelect(tableAddressSelect),
      .memDataIn(memDataIn), .unloadShift(unloadShift), .pipeClockEnable(pipeClockEnable),
      .loadCycleClear(loadCycleClear), .loadSelect(loadSelect), .writeCount(writeCount),
      .unloadWord(unloadWord));

   spb_video_reader u_spb_video_reader (.core_clk(core_clk), .rst(rst), .readStart(readStart),
      .unloadWord(unloadWord), .unloadShift(unloadShift), .found(found),
      .foundWord(foundWord));

   // Run is about 1600 cycles; ceiling leaves room without hiding a hang
   always @(posedge core_clk) begin
      cycles++;
      prevCnt <= writeCount;
      if (!rst && prevCnt !== writeCount) seen.push_back(writeCount);
      if (cycles == 8000) begin
         errors++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [59:0] exp, input logic [59:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wait_pce();
      int j;
      j = 0;
      @(posedge core_clk);
      while (pipeClockEnable !== 1'b1 && j < 60) begin
         @(posedge core_clk);
         j++;
      end
   endtask

   // Table word carries address and data together, select set before strobe
   task automatic tbl_write(input logic [7:0] a, input logic [10:0] d);
      memDataIn <= {d, a};
      tableAddressSelect <= 1'b1;
      @(posedge core_clk);
      tableWrite <= 1'b1;
      @(posedge core_clk);
      tableWrite <= 1'b0;
      tableAddressSelect <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic send_seg(input logic v, input logic [10:0] w, input logic [7:0] db,
                           input logic [11:0] c, input logic f);
      wait_pce();
      segValid <= v;
      segWidth <= w;
      segBrightDiff <= db;
      segColor <= c;
      segFlat <= f;
      validNotFinal <= v;
      widthBelowFour <= (w < 11'h004);
      @(posedge core_clk);
   endtask

   task automatic scan_begin();
      scanStart <= 1'b1;
      @(posedge core_clk);
      scanStart <= 1'b0;
      n = 0;
      k = 0;
      while (loadCycleClear !== 1'b1 && k < 200) begin
         @(posedge core_clk);
         k++;
         if (pipeClockEnable === 1'b1) n++;
      end
   endtask

   initial begin
      repeat (16) @(posedge core_clk);
      chk("pceReset", 60'h0, pipeClockEnable);
      chk("selectReset", 60'h0, loadSelect);
      chk("countReset", 60'hff, writeCount);
      chk("wordReset", 60'h0, unloadWord);
      rst <= 1'b0;
      for (int i = 0; i < 256; i++) tbl_write(8'(i), {3'h1, 8'(8'hff - i)});
      wait_pce();
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pipeClockEnable !== 1'b1 && n < 20);
      chk("pcePeriod", 60'h7, 60'(n));
      // Stall takes effect one cycle late, so two edges are skipped
      busEdgeValid <= 1'b0;
      busEdgeInBlock <= 1'b1;
      repeat (2) @(posedge core_clk);
      n = 0;
      repeat (21) begin
         @(posedge core_clk);
         if (pipeClockEnable === 1'b1) n++;
      end
      chk("stallPce", 60'h0, 60'(n));
      busEdgeValid <= 1'b1;
      busEdgeInBlock <= 1'b0;
      scan_begin();
      chk("pceBeforeLoad", 60'h6, 60'(n));
      chk("selectToggled", 60'h1, loadSelect);
      chk("countCleared", 60'hff, writeCount);
      seen.delete();
      send_seg(1'b1, 11'h050, 8'h85, 12'habc, 1'b1);
      send_seg(1'b1, 11'h030, 8'h12, 12'h123, 1'b0);
      send_seg(1'b1, 11'h040, 8'h07, 12'h456, 1'b0);
      send_seg(1'b0, 11'h000, 8'h00, 12'h000, 1'b0);
      send_seg(1'b0, 11'h000, 8'h00, 12'h000, 1'b0);
      repeat (60) @(posedge core_clk);
      // Full buffer refuses the third word and the null fill
      chk("storeCount", 60'h2, 60'(seen.size()));
      if (seen.size() == 2) begin
         chk("firstStore", 60'hfe, seen[0]);
         chk("secondStore", 60'hff, seen[1]);
      end
      scan_begin();
      chk("selectBack", 60'h0, loadSelect);
      readStart <= 1'b1;
      @(posedge core_clk);
      readStart <= 1'b0;
      k = 0;
      while (found !== 1'b1 && k < 1000) begin
         @(posedge core_clk);
         k++;
      end
      chk("markerFound", 60'h1, found);
      // Flat segment: reciprocal 512, so gradient is difference shifted up two
      chk("firstWord", {11'h050, 3'h4, 10'h214, 1'b1, 12'habc, 1'b1}, foundWord[37:0]);
      // Empty decode period: last segment stands in so one marker word lands
      scan_begin();
      seen.delete();
      decodeLast <= 1'b1;
      send_seg(1'b0, 11'h000, 8'h00, 12'h000, 1'b0);
      send_seg(1'b0, 11'h000, 8'h00, 12'h000, 1'b0);
      decodeLast <= 1'b0;
      repeat (60) @(posedge core_clk);
      chk("emptyStores", 60'h2, 60'(seen.size()));
      if (seen.size() == 2) begin
         chk("emptyMarker", 60'hfe, seen[0]);
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
